// ===== sim/bitfield_core_chk.sv
// Port assertions for the bit-field datapath
`timescale 1ns/1ps
`default_nettype none
module bitfield_core_chk (
   input wire logic REF_CLK_I,
   input wire logic RST_B_I,
   input wire logic INSN_VALID_I,
   input wire bitfield_pkg::insn_t INSN_WORD1_I,
   input wire logic READY_O,
   input wire logic DONE_O,
   input wire logic ILLEGAL_O,
   input wire logic MEM_RD_O,
   input wire logic MEM_WR_O,
   input wire bitfield_pkg::word_t MEM_ADDR_O,
   input wire bitfield_pkg::word_t MEM_WDATA_O,
   input wire bitfield_pkg::word_t MEM_RDATA_I
);
   import bitfield_pkg::*;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_B_I);
   function automatic word_t fmask(input insn_t w);
      return (16'hFFFF >> (4'hF - w[7:4])) & (16'hFFFF << w[3:0]);
   endfunction : fmask
   wire logic take = READY_O && INSN_VALID_I;
   a_busy_two_cycles: assert property (take |=> ILLEGAL_O or
      (!READY_O ##1 !READY_O ##1 (READY_O && DONE_O))) else $error("busy span wrong");
   a_done_cause: assert property (DONE_O |-> $past(take, 3))
      else $error("done without instruction");
   a_illegal_cause: assert property (ILLEGAL_O |-> $past(take) && !DONE_O)
      else $error("illegal pulse wrong");
   a_read_cause: assert property (MEM_RD_O |-> $past(take) && !READY_O)
      else $error("read strobe wrong");
   a_addr_even: assert property ((MEM_RD_O || MEM_WR_O) |-> !MEM_ADDR_O[0])
      else $error("odd memory address");
   a_write_addr: assert property (MEM_WR_O |->
      $past(MEM_RD_O, 2) && MEM_ADDR_O == $past(MEM_ADDR_O, 2)) else $error("write address");
   a_write_merge: assert property (MEM_WR_O |->
      ((MEM_WDATA_O ^ $past(MEM_RDATA_I)) & ~fmask($past(INSN_WORD1_I, 3))) == 16'h0000)
      else $error("bits outside field changed");
   a_addr_hold: assert property ((READY_O && !INSN_VALID_I) |=>
      $stable(MEM_ADDR_O) && $stable(MEM_WDATA_O)) else $error("address not held");
   c_done: cover property (DONE_O && !MEM_WR_O);
   c_write: cover property (MEM_WR_O);
   c_illegal: cover property (ILLEGAL_O);
endmodule : bitfield_core_chk
bind bitfield_core bitfield_core_chk u_chk (.REF_CLK_I, .RST_B_I, .INSN_VALID_I,
   .INSN_WORD1_I, .READY_O, .DONE_O, .ILLEGAL_O, .MEM_RD_O, .MEM_WR_O, .MEM_ADDR_O,
   .MEM_WDATA_O, .MEM_RDATA_I);
`default_nettype wire

// ===== sim/test_bit_field_extract_insert.sv
// Self-checking bench for the bit-field datapath
`timescale 1ns/1ps
`default_nettype none
module test_bit_field_extract_insert;
   import bitfield_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic vld = 1'b0;
   logic we = 1'b0;
   insn_t w1 = '0;
   insn_t w2 = '0;
   nib_t wa = '0;
   nib_t ra = '0;
   word_t wd = '0;
   word_t mrdata = '0;
   word_t mem_word = '0;
   logic rdy, done, ill, mrd, mwr, g_done, g_ill, g_wr, g_rdy, g_rd;
   word_t rd, maddr, mwd, g_wd, rv;
   int miscompares = 0;
   int compares = 0;
   always #2 clk = ~clk;
   bitfield_core dut (.REF_CLK_I(clk), .RST_B_I(rst_b), .INSN_VALID_I(vld), .INSN_WORD1_I(w1),
      .INSN_WORD2_I(w2), .READY_O(rdy), .DONE_O(done), .ILLEGAL_O(ill), .REG_WE_I(we),
      .REG_WADDR_I(wa), .REG_WDATA_I(wd), .REG_RADDR_I(ra), .REG_RDATA_O(rd),
      .MEM_RD_O(mrd), .MEM_WR_O(mwr), .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwd),
      .MEM_RDATA_I(mrdata));
   // Data is valid only in the cycle after the strobe, scrambled otherwise
   always @(posedge clk) mrdata <= mrd ? mem_word : ~mrdata;
   task automatic chk_word(input word_t got, input word_t exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_flag(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_flag
   function automatic word_t mk(input nib_t l, input nib_t m);
      return (16'hFFFF >> (4'hF - m)) & (16'hFFFF << l);
   endfunction : mk
   task automatic set_reg(input nib_t n, input word_t v);
      @(posedge clk);
      we <= 1'b1;
      wa <= n;
      wd <= v;
      @(posedge clk);
      we <= 1'b0;
   endtask : set_reg
   task automatic get_reg(input nib_t n);
      @(posedge clk);
      ra <= n;
      @(posedge clk);
      @(negedge clk);
      rv = rd;
   endtask : get_reg
   task automatic run(input insn_t a, input insn_t b);
      @(posedge clk);
      w1 <= a;
      w2 <= b;
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      g_done = 1'b0;
      g_ill = 1'b0;
      g_wr = 1'b0;
      for (int i = 0; i < 6; i++) begin
         @(negedge clk);
         // First cycle after the take shows busy state and read strobe
         if (i == 0) begin
            g_rdy = rdy;
            g_rd = mrd;
         end
         if (done === 1'b1 || ill === 1'b1) begin
            g_done = done;
            g_ill = ill;
            g_wr = mwr;
            g_wd = mwd;
            break;
         end
      end
   endtask : run
   task automatic t_ext_reg();
      nib_t l[4] = '{4'h0, 4'hF, 4'h4, 4'h3};
      nib_t m[4] = '{4'hF, 4'hF, 4'h7, 4'hC};
      for (int i = 0; i < 4; i++) begin
         set_reg(4'h3, 16'hA5C3);
         set_reg(4'h5, 16'hFFFF);
         run({12'h0A8, 4'h5, m[i], l[i]}, {20'h0, 4'h3});
         chk_flag(g_done, 1'b1);
         chk_flag(g_rdy, 1'b0);
         chk_flag(g_rd, 1'b0);
         get_reg(4'h5);
         chk_word(rv, (16'hA5C3 & mk(l[i], m[i])) >> l[i]);
      end
      $display("t_ext_reg finished");
   endtask : t_ext_reg
   task automatic t_ext_ind();
      word_t ea[6] = '{16'h0, 16'h0100, 16'h0100, 16'h0100, 16'h0102, 16'h00FE};
      word_t pa[6] = '{16'h0, 16'h0100, 16'h0102, 16'h00FE, 16'h0102, 16'h00FE};
      mem_word = 16'hBEEF;
      for (int i = 1; i < 6; i++) begin
         set_reg(4'h2, 16'h0100);
         run({12'h0A8, 4'h6, 4'hB, 4'h4}, {17'h0, i[2:0], 4'h2});
         chk_flag(g_rd, 1'b1);
         chk_word(maddr, ea[i]);
         get_reg(4'h6);
         chk_word(rv, 16'h00EE);
         get_reg(4'h2);
         chk_word(rv, pa[i]);
      end
      $display("t_ext_ind finished");
   endtask : t_ext_ind
   task automatic t_mem();
      mem_word = 16'h8001;
      run({12'h0AA, 4'h8, 4'hF, 4'h0}, {8'h0, 16'h1235});
      chk_word(maddr, 16'h1234);
      get_reg(4'h8);
      chk_word(rv, 16'h8001);
      set_reg(4'h7, 16'hFFAB);
      mem_word = 16'h5555;
      run({12'h0A2, 4'h7, 4'h7, 4'h4}, {8'h0, 16'h0200});
      chk_flag(g_wr, 1'b1);
      chk_word(g_wd, 16'h55B5);
      chk_word(maddr, 16'h0200);
      $display("t_mem finished");
   endtask : t_mem
   task automatic t_ins();
      set_reg(4'h4, 16'h1234);
      run({12'h0A0, 4'h7, 4'hB, 4'h4}, {20'h0, 4'h4});
      get_reg(4'h4);
      chk_word(rv, 16'h1AB4);
      set_reg(4'h9, 16'h00FF);
      run({16'h0A40, 4'hF, 4'h8}, {8'h0, 8'hC3, 8'h09});
      get_reg(4'h9);
      chk_word(rv, 16'hC3FF);
      run({16'h0A40, 4'h6, 4'h4}, {8'h0, 8'hFD, 8'h09});
      get_reg(4'h9);
      chk_word(rv, 16'hC3DF);
      // Indirect targets: register insert through [W2++], literal through [--W2]
      set_reg(4'h2, 16'h0300);
      mem_word = 16'h5555;
      run({12'h0A0, 4'h7, 4'h7, 4'h4}, {17'h0, 3'b010, 4'h2});
      chk_flag(g_wr, 1'b1);
      chk_word(g_wd, 16'h55B5);
      chk_word(maddr, 16'h0300);
      run({16'h0A40, 4'h3, 4'h0}, {8'h0, 8'h0A, 8'h52});
      chk_word(g_wd, 16'h555A);
      chk_word(maddr, 16'h0300);
      get_reg(4'h2);
      chk_word(rv, 16'h0300);
      $display("t_ins finished");
   endtask : t_ins
   task automatic t_illegal();
      insn_t a[3] = '{{12'h0A8, 12'h529}, {12'h0A8, 12'h5F0}, {12'hFFF, 12'h5F0}};
      insn_t b[3] = '{24'h000003, 24'h000063, 24'h000003};
      set_reg(4'h5, 16'h1234);
      for (int i = 0; i < 3; i++) begin
         run(a[i], b[i]);
         chk_flag(g_ill, 1'b1);
         chk_flag(g_rdy, 1'b1);
         chk_flag(g_done, 1'b0);
      end
      get_reg(4'h5);
      chk_word(rv, 16'h1234);
      $display("t_illegal finished");
   endtask : t_illegal
   task automatic test_done();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_ext_reg();
      t_ext_ind();
      t_mem();
      t_ins();
      t_illegal();
      test_done();
   end
   initial begin
      #40000;
      miscompares++;
      test_done();
   end
endmodule : test_bit_field_extract_insert
`default_nettype wire

// ===== verilog/bitfield_cfg.svh
// Constants for the bit-field extract and insert datapath
`ifndef BITFIELD_CFG_SVH
`define BITFIELD_CFG_SVH
// What this block does
// - Extract result is placed with the field's lowest bit at destination bit 0.
// - Destination bits above the field width are cleared on extract.
// - Position operand picks the source bit of the field's LSb, 0 to 15.
// - Field length is MSb minus LSb plus one, 1 to 16 bits; there is no width operand.
// - Field LSb position comes from the low nibble of the first word.
// - Field MSb position comes from bits 7 to 4 of the first word.
// - Memory extract: prefix 0000 1010 1010, destination, MSb, LSb; address in word two.
// - Register insert: prefix 0000 1010 0000; word two holds mode and target register.
// - Insert into memory: prefix 0000 1010 0010; word two holds the address.
// - Literal insert: prefix 0000 1010 0100 0000; word two holds literal, mode, register.
// - Insert overwrites only bits inside the field, with the source data shifted up to the LSb.
// - Insert data comes from source bit 0 upward; higher bits are ignored.
// - Literal insert takes the field from the low bits of an 8-bit literal.
// - Memory forms address a data word, address 0 to 65534.
// - A 3-bit mode field selects direct, indirect or pre/post modified indirect.
// - Extract's first-word register nibble names the destination register.
// - Register insert's second-word nibble names the register receiving the field.
// - Literal insert's second word carries the eight literal bits.
`define PFX_EXT_REG 12'h0A8
`define PFX_EXT_MEM 12'h0AA
`define PFX_INS_REG 12'h0A0
`define PFX_INS_MEM 12'h0A2
`define PFX_INS_LIT 16'h0A40
`define W1_PFX_MSB 23
`define W1_PFX_LSB 12
`define W1_LITPFX_LSB 8
`define W1_REG_MSB 11
`define W1_REG_LSB 8
`define W1_MSB_NIB_MSB 7
`define W1_MSB_NIB_LSB 4
`define W1_LSB_NIB_MSB 3
`define W1_LSB_NIB_LSB 0
`define W2_HIGH_MSB 23
`define W2_HIGH_LSB 16
`define W2_LIT_MSB 15
`define W2_LIT_LSB 8
`define W2_PAD_BIT 7
`define W2_MODE_MSB 6
`define W2_MODE_LSB 4
`define W2_REG_MSB 3
`define W2_REG_LSB 0
`define W2_ADDR_MSB 15
`define W2_ADDR_LSB 0
`define PTR_STEP 16'h0002
`define WORD_RESET 16'h0000
`endif

// ===== verilog/bitfield_core.sv
// Bit-field extract and insert execution datapath with working registers
`timescale 1ns/1ps
`default_nettype none
`include "bitfield_cfg.svh"
module bitfield_core #(
   parameter int WORD_W = 16,
   parameter int REG_COUNT = 16
) (
   input wire logic REF_CLK_I,
   input wire logic RST_B_I,
   input wire logic INSN_VALID_I,
   input wire bitfield_pkg::insn_t INSN_WORD1_I,
   input wire bitfield_pkg::insn_t INSN_WORD2_I,
   output logic READY_O,
   output logic DONE_O,
   output logic ILLEGAL_O,
   input wire logic REG_WE_I,
   input wire bitfield_pkg::nib_t REG_WADDR_I,
   input wire bitfield_pkg::word_t REG_WDATA_I,
   input wire bitfield_pkg::nib_t REG_RADDR_I,
   output bitfield_pkg::word_t REG_RDATA_O,
   output logic MEM_RD_O,
   output logic MEM_WR_O,
   output bitfield_pkg::word_t MEM_ADDR_O,
   output bitfield_pkg::word_t MEM_WDATA_O,
   input wire bitfield_pkg::word_t MEM_RDATA_I
);
   import bitfield_pkg::*;

   if (WORD_W != 16 || REG_COUNT != 16) begin : g_bad_param
      $error("bitfield_core: only 16-bit words and 16 registers are served");
   end

   // Pointer value seen by the access for a given addressing mode
   function automatic word_t access_addr(input mode_e mode, input word_t ptr);
      word_t a;
      a = ptr;
      if (mode == AM_PREINC) begin
         a = ptr + `PTR_STEP;
      end else if (mode == AM_PREDEC) begin
         a = ptr - `PTR_STEP;
      end
      return a;
   endfunction : access_addr

   // Pointer value left behind after the access
   function automatic word_t pointer_after(input mode_e mode, input word_t ptr);
      word_t a;
      a = ptr;
      if (mode == AM_POSTINC || mode == AM_PREINC) begin
         a = ptr + `PTR_STEP;
      end else if (mode == AM_POSTDEC || mode == AM_PREDEC) begin
         a = ptr - `PTR_STEP;
      end
      return a;
   endfunction : pointer_after

   function automatic logic mode_legal(input logic [2:0] m);
      return m <= AM_PREDEC;
   endfunction : mode_legal

   logic rst_meta_b;
   logic rst_sync_b;
   core_s q_reg;
   core_s q_next;

   logic dec_ok;
   op_e dec_op;
   mode_e dec_mode;
   nib_t dec_lsb;
   nib_t dec_msb;
   nib_t dec_wreg;
   nib_t dec_preg;
   word_t dec_addr;
   logic [7:0] dec_imm;
   logic dec_indirect;
   logic dec_mem;

   word_t ex_operand;
   word_t ex_insert_data;
   word_t ex_result;
   logic ex_insert;

   // Reset release through two stages
   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // Instruction decode of both words
   always_comb begin
      logic [11:0] pfx;
      logic [15:0] lpfx;
      logic w2_high_zero;
      logic w2_reg_form_ok;
      pfx = INSN_WORD1_I[`W1_PFX_MSB:`W1_PFX_LSB];
      lpfx = INSN_WORD1_I[`W1_PFX_MSB:`W1_LITPFX_LSB];
      w2_high_zero = INSN_WORD2_I[`W2_HIGH_MSB:`W2_HIGH_LSB] == 8'h00;
      w2_reg_form_ok = w2_high_zero && (INSN_WORD2_I[`W2_LIT_MSB:`W2_LIT_LSB] == 8'h00)
         && !INSN_WORD2_I[`W2_PAD_BIT] && mode_legal(INSN_WORD2_I[`W2_MODE_MSB:`W2_MODE_LSB]);
      dec_lsb = INSN_WORD1_I[`W1_LSB_NIB_MSB:`W1_LSB_NIB_LSB];
      dec_msb = INSN_WORD1_I[`W1_MSB_NIB_MSB:`W1_MSB_NIB_LSB];
      dec_wreg = INSN_WORD1_I[`W1_REG_MSB:`W1_REG_LSB];
      dec_preg = INSN_WORD2_I[`W2_REG_MSB:`W2_REG_LSB];
      dec_addr = INSN_WORD2_I[`W2_ADDR_MSB:`W2_ADDR_LSB];
      dec_imm = INSN_WORD2_I[`W2_LIT_MSB:`W2_LIT_LSB];
      dec_mode = AM_DIRECT;
      dec_op = OP_EXT_REG;
      dec_ok = 1'b0;
      if (lpfx == `PFX_INS_LIT) begin
         dec_op = OP_INS_LIT;
         dec_ok = w2_high_zero && !INSN_WORD2_I[`W2_PAD_BIT]
            && mode_legal(INSN_WORD2_I[`W2_MODE_MSB:`W2_MODE_LSB]);
         dec_mode = mode_e'(INSN_WORD2_I[`W2_MODE_MSB:`W2_MODE_LSB]);
      end else if (pfx == `PFX_EXT_REG) begin
         dec_op = OP_EXT_REG;
         dec_ok = w2_reg_form_ok;
         dec_mode = mode_e'(INSN_WORD2_I[`W2_MODE_MSB:`W2_MODE_LSB]);
      end else if (pfx == `PFX_EXT_MEM) begin
         dec_op = OP_EXT_MEM;
         dec_ok = w2_high_zero;
      end else if (pfx == `PFX_INS_REG) begin
         dec_op = OP_INS_REG;
         dec_ok = w2_reg_form_ok;
         dec_mode = mode_e'(INSN_WORD2_I[`W2_MODE_MSB:`W2_MODE_LSB]);
      end else if (pfx == `PFX_INS_MEM) begin
         dec_op = OP_INS_MEM;
         dec_ok = w2_high_zero;
      end
      // Width is msb - lsb + 1 and must be at least one bit
      if (dec_msb < dec_lsb) begin
         dec_ok = 1'b0;
      end
      dec_indirect = (dec_op == OP_EXT_REG || dec_op == OP_INS_REG || dec_op == OP_INS_LIT)
         && (dec_mode != AM_DIRECT);
      dec_mem = dec_indirect || dec_op == OP_EXT_MEM || dec_op == OP_INS_MEM;
   end

   // Execute-cycle operands
   always_comb begin
      ex_insert = (q_reg.op == OP_INS_REG) || (q_reg.op == OP_INS_MEM)
         || (q_reg.op == OP_INS_LIT);
      ex_operand = q_reg.mem_op ? MEM_RDATA_I : q_reg.regs[q_reg.preg];
      if (q_reg.op == OP_INS_LIT) begin
         ex_insert_data = {8'h00, q_reg.imm};
      end else begin
         ex_insert_data = q_reg.regs[q_reg.wreg];
      end
   end

   bitfield_unit #(
      .WIDTH(WORD_W)
   ) u_field (
      .operand_i(ex_operand),
      .insert_data_i(ex_insert_data),
      .lsb_i(q_reg.lsb),
      .msb_i(q_reg.msb),
      .insert_i(ex_insert),
      .result_o(ex_result)
   );

   // Next-state logic for the whole datapath
   always_comb begin
      q_next = q_reg;
      q_next.done = 1'b0;
      q_next.illegal = 1'b0;
      q_next.mem_rd = 1'b0;
      q_next.mem_wr = 1'b0;
      q_next.reg_rdata = q_reg.regs[REG_RADDR_I];
      unique case (q_reg.state)
         ST_IDLE: begin
            if (REG_WE_I) begin
               q_next.regs[REG_WADDR_I] = REG_WDATA_I;
            end
            if (INSN_VALID_I) begin
               if (!dec_ok) begin
                  q_next.illegal = 1'b1;
               end else begin
                  q_next.state = ST_FETCH;
                  q_next.op = dec_op;
                  q_next.lsb = dec_lsb;
                  q_next.msb = dec_msb;
                  q_next.wreg = dec_wreg;
                  q_next.preg = dec_preg;
                  q_next.imm = dec_imm;
                  q_next.mem_op = dec_mem;
                  q_next.ptr_upd = dec_indirect;
                  q_next.ptr_next = pointer_after(dec_mode, q_next.regs[dec_preg]);
                  q_next.mem_rd = dec_mem;
                  if (dec_indirect) begin
                     q_next.mem_addr = access_addr(dec_mode, q_next.regs[dec_preg]);
                  end else begin
                     // Word address, bit 0 forced even
                     q_next.mem_addr = {dec_addr[15:1], 1'b0};
                  end
               end
            end
         end
         ST_FETCH: begin
            q_next.state = ST_EXEC;
         end
         ST_EXEC: begin
            if (q_reg.ptr_upd) begin
               q_next.regs[q_reg.preg] = q_reg.ptr_next;
            end
            // Result write follows the pointer step so it wins on a clash
            if (!ex_insert) begin
               q_next.regs[q_reg.wreg] = ex_result;
            end else if (q_reg.mem_op) begin
               q_next.mem_wr = 1'b1;
               q_next.mem_wdata = ex_result;
            end else begin
               q_next.regs[q_reg.preg] = ex_result;
            end
            q_next.done = 1'b1;
            q_next.state = ST_IDLE;
         end
         default: begin
            q_next.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   // No status flag port exists; flags stay untouched
   assign READY_O = q_reg.state == ST_IDLE;
   assign DONE_O = q_reg.done;
   assign ILLEGAL_O = q_reg.illegal;
   assign REG_RDATA_O = q_reg.reg_rdata;
   assign MEM_RD_O = q_reg.mem_rd;
   assign MEM_WR_O = q_reg.mem_wr;
   assign MEM_ADDR_O = q_reg.mem_addr;
   assign MEM_WDATA_O = q_reg.mem_wdata;
endmodule : bitfield_core
`default_nettype wire

// ===== verilog/bitfield_pkg.sv
// Types shared by the bit-field datapath
package bitfield_pkg;
   typedef logic [15:0] word_t;
   typedef logic [23:0] insn_t;
   typedef logic [3:0] nib_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_EXEC = 2'b10
   } state_e;
   typedef enum logic [2:0] {
      OP_EXT_REG = 3'b000,
      OP_EXT_MEM = 3'b001,
      OP_INS_REG = 3'b010,
      OP_INS_MEM = 3'b011,
      OP_INS_LIT = 3'b100
   } op_e;
   typedef enum logic [2:0] {
      AM_DIRECT = 3'b000,
      AM_IND = 3'b001,
      AM_POSTINC = 3'b010,
      AM_POSTDEC = 3'b011,
      AM_PREINC = 3'b100,
      AM_PREDEC = 3'b101
   } mode_e;
   typedef struct packed {
      state_e state;
      op_e op;
      nib_t lsb;
      nib_t msb;
      nib_t wreg;
      nib_t preg;
      logic mem_op;
      logic ptr_upd;
      word_t ptr_next;
      logic [7:0] imm;
      logic [15:0][15:0] regs;
      logic mem_rd;
      logic mem_wr;
      word_t mem_addr;
      word_t mem_wdata;
      word_t reg_rdata;
      logic done;
      logic illegal;
   } core_s;
endpackage : bitfield_pkg

// ===== verilog/bitfield_unit.sv
// Combinational field extract and insert unit
`timescale 1ns/1ps
`default_nettype none
module bitfield_unit #(
   parameter int WIDTH = 16
) (
   input wire logic [WIDTH-1:0] operand_i,
   input wire logic [WIDTH-1:0] insert_data_i,
   input wire logic [$clog2(WIDTH)-1:0] lsb_i,
   input wire logic [$clog2(WIDTH)-1:0] msb_i,
   input wire logic insert_i,
   output logic [WIDTH-1:0] result_o
);
   localparam int PW = $clog2(WIDTH);
   logic [WIDTH-1:0] field_mask;
   logic [WIDTH-1:0] low_mask;
   logic [PW-1:0] span;
   logic [WIDTH-1:0] shifted_out;
   logic [WIDTH-1:0] shifted_in;

   if (WIDTH < 2 || (WIDTH & (WIDTH - 1)) != 0) begin : g_bad_width
      $error("bitfield_unit: WIDTH must be a power of two");
   end

   assign span = msb_i - lsb_i;

   for (genvar i = 0; i < WIDTH; i++) begin : g_mask
      // Field covers lsb through msb inclusive
      assign field_mask[i] = (PW'(i) >= lsb_i) && (PW'(i) <= msb_i);
      assign low_mask[i] = PW'(i) <= span;
   end

   assign shifted_out = operand_i >> lsb_i;
   assign shifted_in = insert_data_i << lsb_i;

   always_comb begin
      if (insert_i) begin
         // Bits outside the field keep their value
         result_o = (operand_i & ~field_mask) | (shifted_in & field_mask);
      end else begin
         result_o = shifted_out & low_mask;
      end
   end
endmodule : bitfield_unit
`default_nettype wire
